// ==== logic/sink_blink_timing.sv ====
// blink and fade timing for sinks one to four with their timing registers
// assumes the serial register front end gives one-cycle read and write strobes
// on clk_i, with address and data valid during the strobe
// the enable and on-time registers live here too, holding only the bits used
//
// Behaviour
// [R1] off-time register at 0x12, two bits per sink, sink 4 at the top
// [R2] off code 00 none, 01 0.6 s, 10 1.2 s, 11 1.8 s
// [R3] enabled sink with off code 00 stays on without blinking
// [R4] nonzero off code: off for off time, on for on time, repeating
// [R5] enables set in one write start their sequences in the same cycle
// [R6] fade register at 0x13, fade-out in upper nibble, fade-in lower
// [R7] shared on time in bits 7:6 of 0x11: 0.2, 0.6, 0.8, 1.2 s
// [R8] per-sink enable bit, one turns sink on; blinking only while set
// [R9] fade-out code 0000 disables fade, others 0.30 to 5.5 s full scale
// [R10] fade-in uses same table; shorter spans fade proportionally sooner
// [R11] one shared timebase, own counter per sink reloading on phase change
`timescale 1ns/1ns
module sink_blink_timing
  import sink_timing_pkg::*;
#(
  parameter int TICK_CYCLES = sink_timing_pkg::TICK_CYCLES_DEF
)
(
  input  wire logic                                        clk_i,
  input  wire logic                                        rst_b_i,
  input  wire logic [7:0]                                  reg_addr_i,
  input  wire logic [7:0]                                  reg_wdata_i,
  input  wire logic                                        reg_wr_i,
  input  wire logic                                        reg_rd_i,
  output logic      [7:0]                                  reg_rdata_o,
  output logic      [sink_timing_pkg::SINKS-1:0]           sink_on_o,
  output logic      [sink_timing_pkg::SINKS*sink_timing_pkg::LEVEL_W-1:0] sink_level_o
);
  import sink_timing_pkg::*;

  logic [SINKS-1:0]   per_sink_enable;
  logic [1:0]         shared_on_time;
  logic [7:0]         sink_off_time_group_b;
  logic [7:0]         sink_fade_rates;
  logic [31:0]        div_cnt;
  logic               tick;
  // per-sink phase and down counter, reloaded at every entry to the on or off phase
  phase_t             phase     [SINKS];
  logic [PHASE_W-1:0] phase_cnt [SINKS];

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // off code of one sink, picked out of the packed off-time register
  function automatic logic [1:0] off_code(input logic [7:0] packed_codes, input int idx);
    off_code = packed_codes[idx*OFF_FIELD_BITS +: OFF_FIELD_BITS];   // [R1]
  endfunction

  // counter load for a phase of the given length; a zero length never
  // reaches here, the disabled off code is routed away by the callers
  function automatic logic [PHASE_W-1:0] reload(input logic [10:0] length_ms);
    reload = length_ms - 11'd1;
  endfunction

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // enable bits; one write sets a whole group, so its sequences start together
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      per_sink_enable <= ENABLE_RESET;
    end else if (reg_wr_i && reg_addr_i == SINK_ENABLE_OFS) begin
      per_sink_enable <= reg_wdata_i[SINKS-1:0];   // [R5] [R8]
    end
  end

  // shared on time, only its two field bits are held
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      shared_on_time <= ON_TIME_RESET;
    end else if (reg_wr_i && reg_addr_i == SINK_ON_TIME_OFS) begin
      shared_on_time <= reg_wdata_i[ON_TIME_LSB +: 2];   // [R7]
    end
  end

  // off codes of sinks one to four, kept packed as written
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sink_off_time_group_b <= OFF_TIME_RESET;
    end else if (reg_wr_i && reg_addr_i == SINK_OFF_TIME_GROUP_OFS) begin
      sink_off_time_group_b <= reg_wdata_i;   // [R1]
    end
  end

  // fade rates taken whole; the ramps split the two nibbles
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sink_fade_rates <= FADE_RESET;
    end else if (reg_wr_i && reg_addr_i == SINK_FADE_RATES_OFS) begin
      sink_fade_rates <= reg_wdata_i;   // [R6]
    end
  end

  // read data is registered; bits this block does not hold read as zero
  // a read and a write on one edge return the value before the write
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        SINK_ENABLE_OFS:         reg_rdata_o <= {4'h0, per_sink_enable};
        SINK_ON_TIME_OFS:        reg_rdata_o <= {shared_on_time, 6'h00};
        SINK_OFF_TIME_GROUP_OFS: reg_rdata_o <= sink_off_time_group_b;   // [R1]
        SINK_FADE_RATES_OFS:     reg_rdata_o <= sink_fade_rates;   // [R6]
        default:                 reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // timebase
  // ----------------------------------------------------------------
  // divider runs free, so every sink sees the same tick grid
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || div_cnt == 32'(TICK_CYCLES - 1)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 32'h1;
    end
  end

  // one ms enable pulse shared by every sink so that all stay in step
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tick <= 1'b0;
    end else begin
      tick <= (div_cnt == 32'(TICK_CYCLES - 1));   // [R11]
    end
  end

  // ----------------------------------------------------------------
  // blink phase per sink
  // ----------------------------------------------------------------
  // enables written together leave idle on the same edge, and the shared
  // tick keeps their counters aligned from then on; a new on or off code
  // takes effect at the next phase change, except an off code cleared to 00, which ends an off phase at once
  // limitation: the first on phase after enable may end up to one tick
  // early, since the tick grid runs free and the enable does not restart it
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < SINKS; i++) begin
        phase[i]     <= PH_IDLE;
        phase_cnt[i] <= '0;
        sink_on_o[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < SINKS; i++) begin
        case (phase[i])
          PH_IDLE: begin
            if (per_sink_enable[i]) begin
              phase[i]     <= PH_ON;   // [R5] [R8]
              phase_cnt[i] <= reload(on_time_ms(shared_on_time));   // [R11]
              sink_on_o[i] <= 1'b1;
            end
          end
          PH_ON: begin
            if (!per_sink_enable[i]) begin
              phase[i]     <= PH_IDLE;   // [R8]
              sink_on_o[i] <= 1'b0;
            end else if (off_code(sink_off_time_group_b, i) == 2'h0) begin
              phase_cnt[i] <= reload(on_time_ms(shared_on_time));   // [R3]
            end else if (tick) begin
              if (phase_cnt[i] == '0) begin
                phase[i]     <= PH_OFF;   // [R4]
                phase_cnt[i] <= reload(off_time_ms(off_code(sink_off_time_group_b, i)));   // [R2] [R11]
                sink_on_o[i] <= 1'b0;
              end else begin
                phase_cnt[i] <= phase_cnt[i] - 11'd1;
              end
            end
          end
          PH_OFF: begin
            if (!per_sink_enable[i]) begin
              phase[i]     <= PH_IDLE;   // [R8]
              sink_on_o[i] <= 1'b0;
            end else if (off_code(sink_off_time_group_b, i) == 2'h0) begin
              phase[i]     <= PH_ON;   // [R3]
              phase_cnt[i] <= reload(on_time_ms(shared_on_time));   // code cleared mid-off: back on at once
              sink_on_o[i] <= 1'b1;
            end else if (tick) begin
              if (phase_cnt[i] == '0) begin
                phase[i]     <= PH_ON;   // [R4]
                phase_cnt[i] <= reload(on_time_ms(shared_on_time));   // [R7] [R11]
                sink_on_o[i] <= 1'b1;
              end else begin
                phase_cnt[i] <= phase_cnt[i] - 11'd1;
              end
            end
          end
          default: begin
            phase[i]     <= PH_IDLE;
            sink_on_o[i] <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // fade ramps
  // ----------------------------------------------------------------
  // all sinks share one fade register, so identical sequences match
  // each ramp keeps its own step counter; the timebase and fade codes are shared
  for (genvar g = 0; g < SINKS; g++) begin : g_ramp
    sink_fade_ramp u_ramp (
      .clk_i      (clk_i),
      .rst_b_i    (rst_b_i),
      .tick_i     (tick),
      .lit_i      (sink_on_o[g]),
      .fade_in_i  (sink_fade_rates[FADE_IN_LSB +: 4]),   // [R10]
      .fade_out_i (sink_fade_rates[FADE_OUT_LSB +: 4]),   // [R9]
      .level_o    (sink_level_o[g*LEVEL_W +: LEVEL_W])
    );
  end

endmodule

// ==== pkg/sink_timing_pkg.sv ====
// shared constants for the sink blink and fade timing block
// assumes a 125 MHz core clock and one-millisecond timebase ticks
package sink_timing_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SINK_ENABLE_OFS         = 8'h10;
  localparam logic [7:0] SINK_ON_TIME_OFS        = 8'h11;
  localparam logic [7:0] SINK_OFF_TIME_GROUP_OFS = 8'h12;
  localparam logic [7:0] SINK_FADE_RATES_OFS     = 8'h13;

  localparam int SINKS          = 4;
  localparam int ON_TIME_LSB    = 6;
  localparam int OFF_FIELD_BITS = 2;
  localparam int FADE_OUT_LSB   = 4;
  localparam int FADE_IN_LSB    = 0;

  localparam logic [3:0] ENABLE_RESET   = 4'h0;
  localparam logic [1:0] ON_TIME_RESET  = 2'h0;
  localparam logic [7:0] OFF_TIME_RESET = 8'h00;
  localparam logic [7:0] FADE_RESET     = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 8;
  localparam int TICK_PERIOD_NS  = 1_000_000;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PHASE_W         = 11;
  localparam int LEVEL_W         = 5;
  localparam logic [4:0] LEVEL_FULL = 5'h1E;   // one step per mA of full scale
  localparam int FADE_STEP_W     = 8;

  typedef enum logic [1:0] {PH_IDLE, PH_ON, PH_OFF} phase_t;

  // on time in ms
  function automatic logic [10:0] on_time_ms(input logic [1:0] code);
    case (code)
      2'h0:    on_time_ms = 11'd200;
      2'h1:    on_time_ms = 11'd600;
      2'h2:    on_time_ms = 11'd800;
      default: on_time_ms = 11'd1200;
    endcase
  endfunction

  // off time in ms, zero means no off phase
  function automatic logic [10:0] off_time_ms(input logic [1:0] code);
    case (code)
      2'h1:    off_time_ms = 11'd600;
      2'h2:    off_time_ms = 11'd1200;
      2'h3:    off_time_ms = 11'd1800;
      default: off_time_ms = 11'd0;
    endcase
  endfunction

  // full-scale fade duration in ms, zero means fading disabled
  function automatic logic [12:0] fade_ms(input logic [3:0] code);
    case (code)
      4'hB:    fade_ms = 13'd3500;
      4'hC:    fade_ms = 13'd4000;
      4'hD:    fade_ms = 13'd4500;
      4'hE:    fade_ms = 13'd5000;
      4'hF:    fade_ms = 13'd5500;
      default: fade_ms = 13'(code * 13'd300);
    endcase
  endfunction

endpackage

// ==== logic/sink_fade_ramp.sv ====
// one sink's current ramp: walks the level toward its target in steps
// assumes a one-cycle ms tick and fade codes held stable by the register file
`timescale 1ns/1ns
module sink_fade_ramp
  import sink_timing_pkg::*;
(
  input  wire logic                               clk_i,
  input  wire logic                               rst_b_i,
  input  wire logic                               tick_i,
  input  wire logic                               lit_i,
  input  wire logic [3:0]                         fade_in_i,
  input  wire logic [3:0]                         fade_out_i,
  output logic      [sink_timing_pkg::LEVEL_W-1:0] level_o
);
  import sink_timing_pkg::*;

  logic [LEVEL_W-1:0]     target;
  logic [3:0]             code;
  logic [FADE_STEP_W-1:0] step_ticks;
  logic [FADE_STEP_W-1:0] step_cnt;

  // ----------------------------------------------------------------
  // step length
  // ----------------------------------------------------------------
  // fixed time per level, so a shorter span finishes proportionally sooner
  always_comb begin
    target     = lit_i ? LEVEL_FULL : '0;
    code       = lit_i ? fade_in_i : fade_out_i;
    step_ticks = FADE_STEP_W'(fade_ms(code) / 13'(LEVEL_FULL));
  end

  // ----------------------------------------------------------------
  // ramp
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      level_o  <= '0;
      step_cnt <= '0;
    end else if (level_o == target) begin
      step_cnt <= '0;
    end else if (code == 4'h0) begin
      level_o  <= target;   // [R9] [R10]
      step_cnt <= '0;
    end else if (tick_i) begin
      if (step_cnt >= step_ticks - 8'h01) begin
        level_o  <= (level_o < target) ? level_o + 5'h01 : level_o - 5'h01;   // [R9] [R10]
        step_cnt <= '0;
      end else begin
        step_cnt <= step_cnt + 8'h01;
      end
    end
  end

endmodule

// ==== test/sink_blink_timing_sva.sv ====
// checker for the sink timing block: register reads, blink phases, levels
// assumes it is bound onto sink_blink_timing and sees only its ports
`timescale 1ns/1ns
module sink_blink_timing_sva
#(parameter int TICK_CYCLES = 10)
(
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic [3:0]  sink_on_o,
  input wire logic [19:0] sink_level_o
);
  // ----------
  // shadow registers and phase timer
  // ----------
  localparam int ON_MS [4] = '{200, 600, 800, 1200};
  logic [7:0] sh [4];
  logic       prev;
  int         run;
  int         on_t;
  wire logic       mapped = reg_addr_i[7:2] == 6'h04;
  wire logic [7:0] rexp = mapped ? sh[reg_addr_i[1:0]] : 8'h00;
  wire logic [3:0] hold = sink_on_o & sh[0][3:0] & {sh[2][7:6] == 0, sh[2][5:4] == 0, sh[2][3:2] == 0, sh[2][1:0] == 0};
  assign on_t = ON_MS[sh[1][7:6]] * TICK_CYCLES;
  // unheld bits masked so the shadow matches what reads return
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sh <= '{default: 8'h00};
    end else if (reg_wr_i && mapped) begin
      sh[reg_addr_i[1:0]] <= reg_wdata_i & (reg_addr_i[1:0] == 0 ? 8'h0F : reg_addr_i[1:0] == 1 ? 8'hC0 : 8'hFF);
    end
  end
  // cycles spent at the present level of sink two
  always_ff @(posedge clk_i) begin
    prev <= sink_on_o[1];
    run <= (sink_on_o[1] != prev) ? 1 : run + 1;
  end
  // ----------
  // properties
  // ----------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_enable;
    reg_wr_i && reg_addr_i == 8'h10 && sh[0][3:0] == 4'h0 && reg_wdata_i[3:0] != 4'h0;
  endsequence
  sequence s_dark;
    (sink_on_o == 4'h0) [*3];
  endsequence
  property p_reset;
    disable iff (1'b0) !rst_b_i |=> sink_on_o == 4'h0 && reg_rdata_o == 8'h00 && sink_level_o == 20'h00000;
  endproperty
  property p_read;
    reg_rd_i |=> reg_rdata_o == $past(rexp);
  endproperty
  property p_hold;
    !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  property p_start;
    s_enable |-> ##2 sink_on_o == $past(reg_wdata_i[3:0], 2);
  endproperty
  property p_stop;
    reg_wr_i && reg_addr_i == 8'h10 && reg_wdata_i[3:0] == 4'h0 |-> ##2 s_dark;
  endproperty
  property p_steady;
    !reg_wr_i |=> (sink_on_o & $past(hold)) == $past(hold);
  endproperty
  property p_on_len;
    prev && !sink_on_o[1] && sh[0][1] |-> run >= on_t - TICK_CYCLES && run <= on_t + TICK_CYCLES;
  endproperty
  property p_step;
    sh[3][7:4] != 0 && sh[3][3:0] != 0 |=> sink_level_o[4:0] - $past(sink_level_o[4:0]) inside {5'h00, 5'h01, 5'h1F};
  endproperty
  property p_full;
    (sink_on_o[0] && sh[3] == 8'h00) [*3] |-> sink_level_o[4:0] == 5'h1E;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared");
  a_read: assert property (p_read) else $error("read data wrong");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_start: assert property (p_start) else $error("sinks did not start together");
  a_stop: assert property (p_stop) else $error("sink still on after disable");
  a_steady: assert property (p_steady) else $error("steady sink blinked");
  a_on_len: assert property (p_on_len) else $error("on phase length wrong");
  a_step: assert property (p_step) else $error("level jumped while fading");
  a_full: assert property (p_full) else $error("level not full without fade");
endmodule
bind sink_blink_timing sink_blink_timing_sva #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clk_i, .rst_b_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sink_on_o, .sink_level_o);

// ==== test/sink_blink_timing_bench.sv ====
// bench for the sink timing block: register traffic, blink patterns, fades
// assumes a ten-cycle tick, so one millisecond is ten clocks
`timescale 1ns/1ns
module sink_blink_timing_bench;
  localparam int ON_MS [4] = '{200, 600, 800, 1200};
  logic        clk_i, rst_b_i, reg_wr_i, reg_rd_i;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [3:0]  sink_on_o;
  logic [19:0] sink_level_o;
  logic [31:0] seed = 32'hBD7A93E8;
  logic [7:0]  mdl [4] = '{default: 8'h00};
  int          miscompares = 0;
  int          samples_checked = 0;
  sink_blink_timing #(.TICK_CYCLES(10)) dut_u (.clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .sink_on_o, .sink_level_o);
  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // sinks restart with the on phase, so position in the period decides
  function automatic logic lit(int on, int off, int t);
    return off == 0 || t % (on + off) < on;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // extra edge at the end so the strobe never rises in the step it fell
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    if (a[7:2] == 6'h04) mdl[a[1:0]] = d & (a[1:0] == 0 ? 8'h0F : a[1:0] == 1 ? 8'hC0 : 8'hFF);
    @(negedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    @(negedge clk_i);
    check(reg_rdata_o, a[7:2] == 6'h04 ? mdl[a[1:0]] : 8'h00);
  endtask
  task automatic results();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // watchdog: the run needs about 75k clocks, so 90k means a hang
  initial begin
    repeat (90000) @(posedge clk_i);
    miscompares++;
    results();
  end
  initial begin
    logic [31:0] r;
    logic [7:0]  a;
    logic        e;
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    rst_b_i = 1'b0;
    repeat (20) @(negedge clk_i);
    rst_b_i = 1'b1;
    // random traffic around the map, enables kept clear
    for (int i = 0; i < 40; i++) begin
      r = xs();
      a = 8'h0E + 8'(r[2:0]);
      if (i > 5 && r[8]) wr(a, a == 8'h10 ? r[23:16] & 8'hF0 : r[23:16]);
      rd(a);
    end
    wr(8'h13, 8'h00);
    wr(8'h12, 8'hE4);
    // every on code against off codes 00 to 11 on sinks one to four
    for (int oc = 0; oc < 4; oc++) begin
      wr(8'h11, 8'(oc << 6));
      wr(8'h10, 8'h0F);
      repeat (500) @(negedge clk_i);
      for (int k = 0; k < 15; k++) begin
        for (int s = 0; s < 4; s++) begin
          e = lit(ON_MS[oc], 600 * ((8'hE4 >> (2 * s)) & 3), 100 * k + 50);
          check(8'(sink_on_o[s]), 8'(e));
          check(8'(sink_level_o[5 * s +: 5]), e ? 8'h1E : 8'h00);
        end
        repeat (1000) @(negedge clk_i);
      end
      wr(8'h10, 8'h00);
      @(negedge clk_i);
      check(8'(sink_on_o), 8'h00);
    end
    // fade in 200 clocks a step, fade out 100 clocks a step
    wr(8'h13, 8'h12);
    wr(8'h12, 8'h00);
    wr(8'h10, 8'h01);
    repeat (1550) @(negedge clk_i);
    check(8'(sink_level_o[4:0] inside {[5'h06:5'h08]}), 8'h01);
    repeat (5000) @(negedge clk_i);
    check(8'(sink_level_o == 20'h0001E), 8'h01);
    wr(8'h10, 8'h00);
    repeat (1550) @(negedge clk_i);
    check(8'(sink_level_o[4:0] inside {[5'h0E:5'h10]}), 8'h01);
    repeat (2000) @(negedge clk_i);
    check(8'(sink_level_o == 20'h00000), 8'h01);
    // slowest fade-in code: 5.5 s over 30 levels, first step near 1830 clocks
    wr(8'h13, 8'h0F);
    wr(8'h10, 8'h01);
    repeat (2500) @(negedge clk_i);
    check(8'(sink_level_o[4:0]), 8'h01);
    results();
  end
endmodule
